// ---- verilog/swm_pkg.sv ----
// shared constants and types for the single-wire bus master
// assumes a 10 MHz mclk; all slot timing is counted in mclk cycles
package swm_pkg;

   // ========================================================
   // clock
   localparam int CLK_PERIOD_NS = 100;

   // ========================================================
   // line timing, in microseconds as specified
   localparam int RESET_LOW_TIME_US     = 480; // reset_low_time, least
   localparam int RESET_HIGH_TIME_US    = 480; // line released after reset, least
   localparam int PRESENCE_WAIT_TIME_US = 60;  // presence_wait_time, longest
   localparam int PRESENCE_LOW_TIME_US  = 60;  // presence_low_time, least
   localparam int PRESENCE_SAMPLE_US    = PRESENCE_WAIT_TIME_US + 10;
   localparam int WRITE1_LOW_US         = 6;   // inside 1..15
   localparam int WRITE0_LOW_US         = 65;  // inside 60..120
   localparam int READ_LOW_US           = 1;   // least low time of a read slot
   localparam int READ_SAMPLE_US        = 13;  // device data valid until 15
   localparam int SLOT_TIME_US          = 70;  // inside 60..120
   localparam int RECOVERY_US           = 5;   // least, between slots
   localparam int PROG_DELAY_US         = 5;   // line idle before the pulse
   localparam int PROG_PULSE_US         = 480; // program pulse width
   localparam int PROG_VERIFY_US        = 5;   // idle after the pulse
   localparam int LINE_LOW_MAX_US       = 120; // longest non-reset low

   // ========================================================
   // conversion: least times round up, longest times round down
   function automatic int cycMin(input int us);
      return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   function automatic int cycMax(input int us);
      return (us * 1000) / CLK_PERIOD_NS;
   endfunction

   localparam int RESET_LOW_CYC   = cycMin(RESET_LOW_TIME_US);
   localparam int RESET_HIGH_CYC  = cycMin(RESET_HIGH_TIME_US);
   localparam int PRES_SAMPLE_CYC = cycMin(PRESENCE_SAMPLE_US);
   localparam int WRITE1_LOW_CYC  = cycMin(WRITE1_LOW_US);
   localparam int WRITE0_LOW_CYC  = cycMin(WRITE0_LOW_US);
   localparam int READ_LOW_CYC    = cycMin(READ_LOW_US);
   localparam int READ_SAMPLE_CYC = cycMax(READ_SAMPLE_US);
   localparam int SLOT_CYC        = cycMin(SLOT_TIME_US + RECOVERY_US);
   localparam int PROG_DELAY_CYC  = cycMin(PROG_DELAY_US);
   localparam int PROG_PULSE_CYC  = cycMin(PROG_PULSE_US);
   localparam int PROG_VERIFY_CYC = cycMin(PROG_VERIFY_US);
   localparam int LINE_LOW_MAX_CYC = cycMax(LINE_LOW_MAX_US);

   // ========================================================
   // crc: x^8 + x^5 + x^4 + 1, reflected for lsb-first shifting
   localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
   localparam logic [7:0] CRC_INIT      = 8'h00;

   // ========================================================
   // user commands
   typedef enum logic [2:0] {
      CMD_RESET,
      CMD_WRITE_BIT,
      CMD_READ_BIT,
      CMD_WRITE_BYTE,
      CMD_READ_BYTE,
      CMD_PROGRAM,
      CMD_CRC_CLEAR
   } swm_cmd_t;

   // ========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RST_LOW,
      ST_RST_HIGH,
      ST_SLOT_LOW,
      ST_SLOT_REST,
      ST_PROG_DLY,
      ST_PROG_PULSE,
      ST_PROG_VFY
   } swm_state_t;

endpackage

// ---- verilog/swm_crc_if.sv ----
// carrier between the bus sequencer and its crc generator
// assumes both ends share mclk; shift and clear act on the same edge
`timescale 1ns/10ps
`default_nettype none

interface swm_crc_if;
   logic       clear;    // restart at the initial value
   logic       shiftEn;  // take one bit this cycle
   logic       din;      // bit to take, lsb-first order
   logic [7:0] crc;      // running remainder
   logic       zero;     // remainder is zero, registered

   modport ctrl (output clear, output shiftEn, output din, input crc, input zero);
   modport gen  (input clear, input shiftEn, input din, output crc, output zero);
endinterface

`default_nettype wire

// ---- verilog/swm_crc.sv ----
// serial crc generator, one bit a cycle, lsb first
// assumes the sequencer pulses shiftEn once per bit on the line
`timescale 1ns/10ps
`default_nettype none

module swm_crc (
   // clock and control
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic ce,
   // sequencer side
   swm_crc_if.gen    cb
);

   typedef struct packed {
      logic [7:0] crc;
      logic       zero;
   } swm_crc_regs_t;

   swm_crc_regs_t s_q;
   swm_crc_regs_t s_d;
   logic          fb;

   // ========================================================
   // next remainder; clear has priority over a shift
   // reflected polynomial step
   always_comb begin
      s_d = s_q;
      fb  = s_q.crc[0] ^ cb.din;
      if (cb.clear) begin
         s_d.crc = swm_pkg::CRC_INIT;
      end else if (cb.shiftEn) begin
         s_d.crc = {1'b0, s_q.crc[7:1]} ^ (fb ? swm_pkg::CRC_POLY_REFL : 8'h00);
      end
      s_d.zero = (s_d.crc == 8'h00);
   end

   // state register, frozen while ce is low
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q.crc  <= swm_pkg::CRC_INIT;
         s_q.zero <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign cb.crc  = s_q.crc;
   assign cb.zero = s_q.zero;

   // ========================================================
   // checks
   property p_crc_poly;
      @(posedge mclk) disable iff (!rstn)
      (ce && !cb.clear && cb.shiftEn && cb.din && cb.crc == 8'h00) |=> (cb.crc == 8'h8C);
   endproperty
   a_crc_poly: assert property (p_crc_poly) else $error("crc step off polynomial");

endmodule

`default_nettype wire

// ---- verilog/swm_master.sv ----
// bus master for a single open-drain data line with program pulse
// assumes an external pull-up on the line and a 12 V switch on progEn
//
// Summary of operation
// - master holds line low 480 us to reset
// - only presence comes from device; master starts rest
// - master opens each slot with falling edge
// - program pulse only after byte crc confirmed; code only checks crc zero, which also holds after reset or CMD_CRC_CLEAR
// - program pulse 12 V for 480 us, then idle
// - all crcs use x^8 + x^5 + x^4 + 1
// - master computes crc and decides alone
// - line idles high; no stray long lows
`timescale 1ns/10ps
`default_nettype none

module swm_master #(
   parameter int RESET_LOW_CYC  = swm_pkg::RESET_LOW_CYC,
   parameter int RESET_HIGH_CYC = swm_pkg::RESET_HIGH_CYC,
   parameter int PROG_PULSE_CYC = swm_pkg::PROG_PULSE_CYC,
   parameter int CNT_W          = 13
) (
   // clock, reset, enable
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              ce,
   // user commands
   input  wire logic              cmdValid,
   input  wire swm_pkg::swm_cmd_t cmdCode,
   input  wire logic [7:0]        wrData,
   output var  logic              busy,
   output var  logic              done,
   output var  logic              err,
   output var  logic [7:0]        rdData,
   output var  logic              presence,
   output var  logic [7:0]        crc,
   output var  logic              crcZero,
   // data line and program switch
   input  wire logic              dqIn,
   output var  logic              dqOut,
   output var  logic              dqOe,
   output var  logic              progEn
);

   // ========================================================
   // elaboration checks
   localparam int CNT_MAX = (1 << CNT_W) - 1;
   if (RESET_LOW_CYC < 1 || RESET_LOW_CYC > CNT_MAX) $error("RESET_LOW_CYC out of range");
   if (RESET_HIGH_CYC <= swm_pkg::PRES_SAMPLE_CYC || RESET_HIGH_CYC > CNT_MAX)
      $error("RESET_HIGH_CYC out of range");
   if (PROG_PULSE_CYC < 1 || PROG_PULSE_CYC > CNT_MAX) $error("PROG_PULSE_CYC out of range");
   if (swm_pkg::SLOT_CYC > CNT_MAX) $error("CNT_W too small for a slot");

   // counter end values at counter width
   localparam logic [CNT_W-1:0] RstLowEnd  = CNT_W'(RESET_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] RstHighEnd = CNT_W'(RESET_HIGH_CYC - 1);
   localparam logic [CNT_W-1:0] PresAt     = CNT_W'(swm_pkg::PRES_SAMPLE_CYC - 1);
   localparam logic [CNT_W-1:0] W1LowEnd   = CNT_W'(swm_pkg::WRITE1_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] W0LowEnd   = CNT_W'(swm_pkg::WRITE0_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] RdLowEnd   = CNT_W'(swm_pkg::READ_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] RdSampleAt = CNT_W'(swm_pkg::READ_SAMPLE_CYC - 1);
   localparam logic [CNT_W-1:0] SlotEnd    = CNT_W'(swm_pkg::SLOT_CYC - 1);
   localparam logic [CNT_W-1:0] PrDlyEnd   = CNT_W'(swm_pkg::PROG_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] PrPulseEnd = CNT_W'(PROG_PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] PrVfyEnd   = CNT_W'(swm_pkg::PROG_VERIFY_CYC - 1);

   typedef struct packed {
      swm_pkg::swm_state_t st;
      logic [CNT_W-1:0]    cnt;
      logic [3:0]          bitsLeft;
      logic [7:0]          sh;
      logic                rdOp;
      logic                byteOp;
      logic                smp;
      logic                dqOe;
      logic                dqOut;
      logic                ppEn;
      logic                busy;
      logic                done;
      logic                err;
      logic                presence;
      logic [7:0]          rdData;
   } swm_regs_t;

   function automatic logic isReadCmd(input swm_pkg::swm_cmd_t c);
      return (c == swm_pkg::CMD_READ_BIT) || (c == swm_pkg::CMD_READ_BYTE);
   endfunction

   function automatic logic isByteCmd(input swm_pkg::swm_cmd_t c);
      return (c == swm_pkg::CMD_WRITE_BYTE) || (c == swm_pkg::CMD_READ_BYTE);
   endfunction

   swm_regs_t  s_q;
   swm_regs_t  s_d;
   logic [1:0] rstSync_q;
   logic       rstn;
   logic       dqMeta_q;
   logic       dqSync_q;
   logic       newBit;
   swm_crc_if  crcBus ();

   // ========================================================
   // reset release and line input synchronisers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstSync_q <= 2'b00;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstn = rstSync_q[1];

   // line level is asynchronous to mclk; only dqSync_q is read
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dqMeta_q <= 1'b1;
         dqSync_q <= 1'b1;
      end else if (ce) begin
         dqMeta_q <= dqIn;
         dqSync_q <= dqMeta_q;
      end
   end

   // ========================================================
   // sequencer next state
   always_comb begin
      s_d                = s_q;
      s_d.done           = 1'b0;
      s_d.cnt            = s_q.cnt + CNT_W'(1);
      newBit             = s_q.rdOp ? s_q.smp : s_q.sh[0];
      crcBus.clear       = 1'b0;
      crcBus.shiftEn     = 1'b0;
      crcBus.din         = newBit;
      case (s_q.st)
         swm_pkg::ST_IDLE: begin
            s_d.cnt = '0;
            if (cmdValid) begin
               s_d.err  = 1'b0;
               s_d.busy = 1'b1;
               case (cmdCode)
                  swm_pkg::CMD_RESET: begin
                     s_d.st       = swm_pkg::ST_RST_LOW;
                     s_d.dqOe     = 1'b1;
                     s_d.presence = 1'b0;
                  end
                  swm_pkg::CMD_WRITE_BIT, swm_pkg::CMD_READ_BIT,
                  swm_pkg::CMD_WRITE_BYTE, swm_pkg::CMD_READ_BYTE: begin
                     s_d.st       = swm_pkg::ST_SLOT_LOW;
                     s_d.dqOe     = 1'b1;
                     s_d.rdOp     = isReadCmd(cmdCode);
                     s_d.byteOp   = isByteCmd(cmdCode);
                     s_d.bitsLeft = isByteCmd(cmdCode) ? 4'h8 : 4'h1;
                     s_d.sh       = wrData;
                  end
                  swm_pkg::CMD_PROGRAM: begin
                     if (crcBus.zero) begin
                        s_d.st = swm_pkg::ST_PROG_DLY;
                     end else begin
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.err  = 1'b1;
                     end
                  end
                  swm_pkg::CMD_CRC_CLEAR: begin
                     crcBus.clear = 1'b1;
                     s_d.busy     = 1'b0;
                     s_d.done     = 1'b1;
                  end
                  default: begin
                     s_d.busy = 1'b0;
                     s_d.done = 1'b1;
                     s_d.err  = 1'b1;
                  end
               endcase
            end
         end
         swm_pkg::ST_RST_LOW: begin
            if (s_q.cnt == RstLowEnd) begin
               s_d.dqOe = 1'b0;
               s_d.cnt  = '0;
               s_d.st   = swm_pkg::ST_RST_HIGH;
            end
         end
         // presence is sampled between the latest start and earliest end
         swm_pkg::ST_RST_HIGH: begin
            if (s_q.cnt == PresAt) begin
               s_d.presence = !dqSync_q;
            end
            if (s_q.cnt == RstHighEnd) begin
               s_d.st   = swm_pkg::ST_IDLE;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
            end
         end
         swm_pkg::ST_SLOT_LOW: begin
            if (s_q.cnt == (s_q.rdOp ? RdLowEnd : (s_q.sh[0] ? W1LowEnd : W0LowEnd))) begin
               s_d.dqOe = 1'b0;
               s_d.st   = swm_pkg::ST_SLOT_REST;
            end
         end
         swm_pkg::ST_SLOT_REST: begin
            if (s_q.rdOp && s_q.cnt == RdSampleAt) begin
               s_d.smp = dqSync_q;
            end
            if (s_q.cnt == SlotEnd) begin
               crcBus.shiftEn = 1'b1;
               s_d.sh         = {newBit, s_q.sh[7:1]};
               s_d.bitsLeft   = s_q.bitsLeft - 4'h1;
               if (s_q.bitsLeft == 4'h1) begin
                  s_d.st     = swm_pkg::ST_IDLE;
                  s_d.busy   = 1'b0;
                  s_d.done   = 1'b1;
                  s_d.rdData = s_q.byteOp ? {newBit, s_q.sh[7:1]} : {7'h00, newBit};
               end else begin
                  s_d.st   = swm_pkg::ST_SLOT_LOW;
                  s_d.dqOe = 1'b1;
                  s_d.cnt  = '0;
               end
            end
         end
         swm_pkg::ST_PROG_DLY: begin
            if (s_q.cnt == PrDlyEnd) begin
               s_d.ppEn = 1'b1;
               s_d.cnt  = '0;
               s_d.st   = swm_pkg::ST_PROG_PULSE;
            end
         end
         swm_pkg::ST_PROG_PULSE: begin
            if (s_q.cnt == PrPulseEnd) begin
               s_d.ppEn = 1'b0;
               s_d.cnt  = '0;
               s_d.st   = swm_pkg::ST_PROG_VFY;
            end
         end
         swm_pkg::ST_PROG_VFY: begin
            if (s_q.cnt == PrVfyEnd) begin
               s_d.st   = swm_pkg::ST_IDLE;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
            end
         end
         default: begin
            s_d.st   = swm_pkg::ST_IDLE;
            s_d.dqOe = 1'b0;
            s_d.ppEn = 1'b0;
            s_d.busy = 1'b0;
         end
      endcase
      // ce low must not leak a crc step
      if (!ce) begin
         crcBus.clear   = 1'b0;
         crcBus.shiftEn = 1'b0;
      end
   end

   // state register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{st: swm_pkg::ST_IDLE, cnt: '0, bitsLeft: 4'h0, sh: 8'h00,
                  rdOp: 1'b0, byteOp: 1'b0, smp: 1'b1, dqOe: 1'b0, dqOut: 1'b0,
                  ppEn: 1'b0, busy: 1'b0, done: 1'b0, err: 1'b0, presence: 1'b0,
                  rdData: 8'h00};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   swm_crc u_crc (
      .mclk (mclk),
      .rstn (rstn),
      .ce   (ce),
      .cb   (crcBus.gen)
   );

   // the line is only ever pulled low; the pull-up makes the high
   assign dqOut    = s_q.dqOut;
   assign dqOe     = s_q.dqOe;
   assign progEn   = s_q.ppEn;
   assign busy     = s_q.busy;
   assign done     = s_q.done;
   assign err      = s_q.err;
   assign rdData   = s_q.rdData;
   assign presence = s_q.presence;
   assign crc      = crcBus.crc;
   assign crcZero  = crcBus.zero;

   // ========================================================
   // checker helpers: run lengths and crc at byte start
   logic [CNT_W-1:0] lowRun_q;
   logic [CNT_W-1:0] ppRun_q;
   logic [7:0]       crcAtStart_q;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lowRun_q     <= '0;
         ppRun_q      <= '0;
         crcAtStart_q <= 8'h00;
      end else if (ce) begin
         lowRun_q <= s_q.dqOe ? lowRun_q + CNT_W'(1) : '0;
         ppRun_q  <= s_q.ppEn ? ppRun_q + CNT_W'(1) : '0;
         if (s_q.st == swm_pkg::ST_IDLE && cmdValid) begin
            crcAtStart_q <= crcBus.crc;
         end
      end
   end

   property p_rst_low;
      @(posedge mclk) disable iff (!rstn)
      ($fell(s_q.dqOe) && $past(s_q.st) == swm_pkg::ST_RST_LOW)
         |-> ($past(lowRun_q) >= RESET_LOW_CYC - 1);
   endproperty
   a_rst_low: assert property (p_rst_low) else $error("reset low too short");

   property p_idle_quiet;
      @(posedge mclk) disable iff (!rstn)
      !s_q.busy |-> (!s_q.dqOe && !s_q.ppEn);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("line driven while idle");

   property p_slot_open;
      @(posedge mclk) disable iff (!rstn)
      ($rose(s_q.busy) && s_q.st == swm_pkg::ST_SLOT_LOW) |-> s_q.dqOe;
   endproperty
   a_slot_open: assert property (p_slot_open) else $error("slot not opened low");

   property p_prog_ok;
      @(posedge mclk) disable iff (!rstn)
      $rose(s_q.ppEn) |-> (crcBus.zero && !s_q.dqOe);
   endproperty
   a_prog_ok: assert property (p_prog_ok) else $error("program without crc");

   property p_prog_width;
      @(posedge mclk) disable iff (!rstn)
      $fell(s_q.ppEn) |-> ($past(ppRun_q) >= PROG_PULSE_CYC - 1 && !s_q.dqOe);
   endproperty
   a_prog_width: assert property (p_prog_width) else $error("program pulse short");

   property p_crc_check;
      @(posedge mclk) disable iff (!rstn)
      ($rose(s_q.done) && s_q.rdOp && s_q.byteOp && crcAtStart_q == s_q.rdData)
         |-> crcBus.zero;
   endproperty
   a_crc_check: assert property (p_crc_check) else $error("crc compare failed");

   property p_low_bound;
      @(posedge mclk) disable iff (!rstn)
      (s_q.dqOe && s_q.st != swm_pkg::ST_RST_LOW)
         |-> (lowRun_q < swm_pkg::LINE_LOW_MAX_CYC);
   endproperty
   a_low_bound: assert property (p_low_bound) else $error("line low too long");

   c_presence: cover property (@(posedge mclk) disable iff (!rstn) $rose(s_q.presence));
   c_rd_byte:  cover property (@(posedge mclk) disable iff (!rstn)
                  $rose(s_q.done) && s_q.rdOp && s_q.byteOp);
   c_wr_byte:  cover property (@(posedge mclk) disable iff (!rstn)
                  $rose(s_q.done) && !s_q.rdOp && s_q.byteOp);
   c_program:  cover property (@(posedge mclk) disable iff (!rstn) $fell(s_q.ppEn));

endmodule

`default_nettype wire

// ---- tb/swm_dev_model.sv ----
// behavioural model of the add-only memory device on the data line
// assumes an mclk-rate view of the line; the pull-up lives in the bench
`timescale 1ns/10ps
`default_nettype none

// ========================================================
// device model
module swm_dev_model (
   // clock and line
   input  wire logic       mclk,
   input  wire logic       line,
   // bench controls
   input  wire logic       presEn,
   input  wire logic [7:0] txByte,
   // device outputs
   output var  logic       pullLow,
   output var  logic [7:0] rxByte,
   output var  logic [7:0] devCrc
);
   int         lowCnt    = 0;
   int         sinceFall = 0;
   int         presCnt   = 0;
   logic       lineQ     = 1'b1;
   logic       txBit     = 1'b1;
   logic [2:0] idx       = 3'h0;

   initial begin
      pullLow = 1'b0;
      rxByte  = 8'h00;
      devCrc  = 8'h00;
   end

   // one pass per cycle; a low longer than 120 us counts as a reset
   always @(posedge mclk) begin
      if (!lineQ && line && lowCnt > 1200) begin
         presCnt = 1;
         idx     = 3'h0;
         devCrc  = 8'h00;
      end
      lowCnt = line ? 0 : lowCnt + 1;
      // slot starts on fall, served only while presCnt is zero
      if (lineQ && !line && presCnt == 0) begin
         sinceFall = 1;
         txBit     = txByte[idx];
         idx       = idx + 3'h1;
      end
      if (sinceFall == 300) begin
         rxByte = {line, rxByte[7:1]};
         // crc over every slot bit, sent or taken
         devCrc = (devCrc >> 1) ^ ((devCrc[0] ^ (line && txBit)) ? 8'h8C : 8'h00);
      end
      if (sinceFall > 0) begin
         sinceFall = (sinceFall == 700) ? 0 : sinceFall + 1;
      end
      if (presCnt > 0) begin
         presCnt = (presCnt == 800) ? 0 : presCnt + 1;
      end
      lineQ = line;
      // zero held 15 us
      // non-blocking so the master's input flop never races the pull
      pullLow <= (presEn && presCnt >= 200 && presCnt < 800) ||
                (sinceFall > 0 && sinceFall < 150 && !txBit);
   end
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the single-wire bus master
// assumes the device model above and a pull-up folded into the line
`timescale 1ns/10ps
`default_nettype none

// ========================================================
// bench top
module testbench;
   typedef struct {swm_pkg::swm_cmd_t c; logic [7:0] d; logic [7:0] t; logic [7:0] e;} swm_row_t;

   logic              mclk, resetn, ce, cmdValid, presEn;
   swm_pkg::swm_cmd_t cmdCode;
   logic [7:0]        wrData, txByte, rdData, crc, rxByte, expCrc, devCrc;
   logic              busy, done, err, presence, crcZero, dqOe, dqOut, progEn, pullLow, line;
   int                mismatches, total_checks, cycles, progCnt;
   swm_row_t          rows [5] = '{
      '{swm_pkg::CMD_WRITE_BYTE, 8'h01, 8'hFF, 8'h00},
      '{swm_pkg::CMD_WRITE_BYTE, 8'hC3, 8'hFF, 8'h00},
      '{swm_pkg::CMD_READ_BYTE,  8'h00, 8'h96, 8'h96},
      '{swm_pkg::CMD_READ_BYTE,  8'h00, 8'h00, 8'h00},
      '{swm_pkg::CMD_READ_BIT,   8'h00, 8'hFF, 8'h01}};

   // open-drain line with pull-up: low if either side pulls
   assign line = !(dqOe || pullLow);

   swm_master #(.RESET_LOW_CYC(4800), .RESET_HIGH_CYC(800), .PROG_PULSE_CYC(20), .CNT_W(13))
   i_dut (.mclk(mclk), .resetn(resetn), .ce(ce), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .wrData(wrData), .busy(busy), .done(done), .err(err), .rdData(rdData),
      .presence(presence), .crc(crc), .crcZero(crcZero), .dqIn(line), .dqOut(dqOut),
      .dqOe(dqOe), .progEn(progEn));

   swm_dev_model i_dev (.mclk(mclk), .line(line), .presEn(presEn), .txByte(txByte),
      .pullLow(pullLow), .rxByte(rxByte), .devCrc(devCrc));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask

   // reflected x^8+x^5+x^4+1, lsb first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
      return c;
   endfunction

   // one command; cmdValid held a full cycle, then wait for done
   task automatic run(input swm_pkg::swm_cmd_t c, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge mclk);
      cmdValid = 1'b1;
      cmdCode  = c;
      wrData   = d;
      @(negedge mclk);
      cmdValid = 1'b0;
      while (done !== 1'b1 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
      chk(n < 20000, "no done");
   endtask

   // cycle ceiling, program pulse width and drive clash watch
   always @(posedge mclk) begin
      cycles++;
      if (progEn === 1'b1) progCnt++;
      if (progEn === 1'b1 && dqOe !== 1'b0) chk(1'b0, "line pulled during program");
      if (dqOe === 1'b1 && dqOut !== 1'b0) chk(1'b0, "line driven high");
      if (cycles == 80000) begin
         mismatches++;
         close_out();
      end
   end

   initial begin
      {ce, cmdValid, wrData, presEn, resetn, progCnt, cycles} = '0;
      {mismatches, total_checks} = '0;
      ce      = 1'b1;
      presEn  = 1'b1;
      txByte  = 8'hFF;
      cmdCode = swm_pkg::CMD_RESET;
      repeat (20) @(negedge mclk);
      resetn = 1'b1;
      chk(busy === 1'b0 && dqOe === 1'b0 && progEn === 1'b0 && crcZero === 1'b1, "reset");
      repeat (3) @(negedge mclk);
      run(swm_pkg::CMD_RESET, 8'h00);
      chk(presence === 1'b1, "presence missed");
      foreach (rows[i]) begin
         txByte = rows[i].t;
         run(rows[i].c, rows[i].d);
         if (rows[i].c == swm_pkg::CMD_WRITE_BYTE) chk(rxByte === rows[i].d, "write");
         else chk(rdData === rows[i].e, "read");
      end
      presEn = 1'b0;
      run(swm_pkg::CMD_RESET, 8'h00);
      chk(presence === 1'b0, "false presence");
      presEn = 1'b1;
      txByte = 8'hFF;
      run(swm_pkg::CMD_RESET, 8'h00);
      // crc over a written byte, then its crc read back
      run(swm_pkg::CMD_CRC_CLEAR, 8'h00);
      run(swm_pkg::CMD_WRITE_BYTE, 8'hA5);
      expCrc = crc8(8'h00, 8'hA5);
      chk(crc === expCrc && devCrc === expCrc, "crc value");
      txByte = devCrc;
      run(swm_pkg::CMD_READ_BYTE, 8'h00);
      chk(rdData === expCrc && crcZero === 1'b1 && devCrc === 8'h00, "crc ok");
      progCnt = 0;
      run(swm_pkg::CMD_PROGRAM, 8'h00);
      chk(err === 1'b0 && progCnt == 20, "program pulse");
      txByte = 8'hFF;
      run(swm_pkg::CMD_WRITE_BYTE, 8'h5A);
      progCnt = 0;
      run(swm_pkg::CMD_PROGRAM, 8'h00);
      chk(err === 1'b1 && progCnt == 0, "program unconfirmed");
      run(swm_pkg::swm_cmd_t'(3'h7), 8'h00);
      chk(err === 1'b1, "bad code");
      // mid-run reset: a byte in flight is cut and the line let go
      @(negedge mclk);
      cmdValid = 1'b1;
      cmdCode  = swm_pkg::CMD_WRITE_BYTE;
      wrData   = 8'h00;
      @(negedge mclk);
      cmdValid = 1'b0;
      repeat (100) @(negedge mclk);
      chk(busy === 1'b1 && dqOe === 1'b1, "slot not open");
      resetn = 1'b0;
      #1;
      chk(busy === 1'b0 && dqOe === 1'b0 && err === 1'b0 && crcZero === 1'b1, "mid reset");
      repeat (20) @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      run(swm_pkg::CMD_RESET, 8'h00);
      chk(presence === 1'b1, "presence after mid reset");
      run(swm_pkg::CMD_CRC_CLEAR, 8'h00);
      chk(err === 1'b0 && crcZero === 1'b1 && line === 1'b1, "clear and idle");
      close_out();
   end
endmodule

`default_nettype wire
